// ===== timer0_pkg.sv
package timer0_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFFSET_OPTION    = 8'h00;
    localparam logic [7:0] OFFSET_COUNT     = 8'h04;
    localparam logic [7:0] OFFSET_INTCTL    = 8'h08;
    localparam logic [7:0] OFFSET_DIRECTION = 8'h0C;
    localparam logic [7:0] OFFSET_STATUS    = 8'h10;
    localparam logic [7:0] OFFSET_MASK      = 8'h14;

    localparam logic [7:0] OPTION_RESET     = 8'hFF;
    localparam logic [7:0] COUNT_RESET      = 8'h00;
    localparam logic [7:0] INTCTL_RESET     = 8'h00;
    localparam logic [5:0] DIRECTION_RESET  = 6'h3F;
    localparam logic [1:0] EVENT_RESET      = 2'h0;
    localparam logic [7:0] COUNT_TOP        = 8'hFF;
    localparam logic [7:0] PRESCALE_RESET   = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int OPT_PULLUP_DISABLE = 7;
    localparam int OPT_EXT_EDGE       = 6;
    localparam int OPT_SOURCE         = 5;
    localparam int OPT_COUNT_EDGE     = 4;
    localparam int OPT_ASSIGN         = 3;
    localparam int OPT_RATE_LSB       = 0;
    localparam int INT_OVF_ENABLE     = 5;
    localparam int INT_EXT_ENABLE     = 4;
    localparam int INT_OVF_FLAG       = 2;
    localparam int INT_EXT_FLAG       = 1;
    localparam int EVT_OVERFLOW       = 0;
    localparam int EVT_EXT_EDGE       = 1;

    // ****************************************
    // Phase clocks, four system clocks per instruction cycle
    // ****************************************
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

endpackage : timer0_pkg

// ===== prescaler_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prescaler_if;
    logic       tick_in;
    logic       clear;
    logic       to_watchdog;
    logic [2:0] rate;
    logic       tick_out;

    modport owner (output tick_in, output clear, output to_watchdog, output rate, input tick_out);
    modport unit  (input tick_in, input clear, input to_watchdog, input rate, output tick_out);
endinterface : prescaler_if
`default_nettype wire

// ===== shared_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module shared_prescaler
    import timer0_pkg::*;
(
    input wire logic   clock,
    input wire logic   reset,
    prescaler_if.unit  pif
);
    logic [7:0] count_q;
    logic [3:0] ratio_log;
    logic [7:0] ratio_mask;

    // The watchdog ratio starts at 1:1, the timer ratio one step higher.
    assign ratio_log = pif.to_watchdog ? {1'b0, pif.rate} : ({1'b0, pif.rate} + 4'h1);

    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign ratio_mask[i] = (4'(i) < ratio_log);
    end

    assign pif.tick_out = pif.tick_in & ((count_q & ratio_mask) == ratio_mask);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= PRESCALE_RESET;
        end else if (pif.clear) begin
            count_q <= PRESCALE_RESET;
        end else if (pif.tick_in) begin
            count_q <= count_q + 8'h01;
        end
    end
endmodule : shared_prescaler
`default_nettype wire

// ===== timer0_shared_prescaler.sv
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module timer0_shared_prescaler
    import timer0_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input_pin,
    input  wire logic        ext_irq_pin,
    input  wire logic        sleep,
    input  wire logic        clear_watchdog_instruction,
    input  wire logic        watchdog_base_tick,
    output logic             watchdog_prescaled_tick,
    output logic             overflow_irq_request,
    output logic             ext_irq_request,
    output logic             pullup_disable,
    output logic [5:0]       pin_direction,
    output logic             irq
);
    // ****************************************
    // Register bus decode
    // ****************************************
    logic [7:0]  option_q;
    logic [7:0]  count_q;
    logic [7:0]  intctl_q;
    logic [5:0]  direction_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic [31:0] prdata_q;

    wire hit_option    = (paddr == OFFSET_OPTION);
    wire hit_count     = (paddr == OFFSET_COUNT);
    wire hit_intctl    = (paddr == OFFSET_INTCTL);
    wire hit_direction = (paddr == OFFSET_DIRECTION);
    wire hit_status    = (paddr == OFFSET_STATUS);
    wire hit_mask      = (paddr == OFFSET_MASK);
    wire hit_any       = hit_option | hit_count | hit_intctl | hit_direction | hit_status | hit_mask;

    wire setup_phase  = psel & ~penable;
    wire access_phase = psel & penable;
    wire write_ok     = access_phase & pwrite & hit_any;

    wire write_option    = write_ok & hit_option;
    wire write_count     = write_ok & hit_count;
    wire write_intctl    = write_ok & hit_intctl;
    wire write_direction = write_ok & hit_direction;
    wire write_status    = write_ok & hit_status;
    wire write_mask      = write_ok & hit_mask;

    // The prescaler count itself has no address at all.
    wire [31:0] read_mux =
        hit_option    ? {24'h00_0000, option_q} :
        hit_count     ? {24'h00_0000, count_q} :
        hit_intctl    ? {24'h00_0000, intctl_q} :
        hit_direction ? {26'h000_0000, direction_q} :
        hit_status    ? {30'h0000_0000, status_q} :
        hit_mask      ? {30'h0000_0000, mask_q} :
                        32'h0000_0000;

    // Read data is captured in the setup cycle so that prdata comes from a flip-flop.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata_q <= read_mux;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = access_phase;
    assign pslverr = access_phase & ~hit_any;

    // ****************************************
    // Option and direction registers
    // ****************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            option_q    <= OPTION_RESET;
            direction_q <= DIRECTION_RESET;
        end else begin
            if (write_option) begin
                option_q <= pwdata[7:0];
            end
            if (write_direction) begin
                direction_q <= pwdata[5:0];
            end
        end
    end

    wire       to_watchdog  = option_q[OPT_ASSIGN];
    wire       source_pin   = option_q[OPT_SOURCE];
    wire       falling_edge = option_q[OPT_COUNT_EDGE];
    wire       ext_rising   = option_q[OPT_EXT_EDGE];
    wire [2:0] rate         = option_q[OPT_RATE_LSB +: 3];

    assign pullup_disable = option_q[OPT_PULLUP_DISABLE];
    assign pin_direction  = direction_q;

    // ****************************************
    // Phase clocks
    // ****************************************
    logic [1:0] phase_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    wire instr_tick   = (phase_q == PHASE_Q4);
    wire sample_phase = (phase_q == PHASE_Q2) | (phase_q == PHASE_Q4);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // A pin level is accepted only after the second and third stages agree, which
    // filters a single-cycle glitch; a pin change reaches pin_rise or pin_fall three cycles later.
    wire [1:0]  pin_raw = {ext_irq_pin, count_input_pin};
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    for (genvar k = 0; k < 2; k++) begin : g_sync
        logic [2:0] stage_q;
        logic       level_q;
        wire        agree = (stage_q[1] == stage_q[2]);

        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                stage_q <= 3'h0;
                level_q <= 1'b0;
            end else begin
                stage_q <= {stage_q[1:0], pin_raw[k]};
                if (agree) begin
                    level_q <= stage_q[2];
                end
            end
        end

        assign pin_rise[k] = agree & stage_q[2] & ~level_q;
        assign pin_fall[k] = agree & ~stage_q[2] & level_q;
    end

    // ****************************************
    // Count source and shared prescaler
    // ****************************************
    prescaler_if pif ();

    wire pin_edge   = falling_edge ? pin_fall[0] : pin_rise[0];
    wire src_event  = (source_pin ? pin_edge : instr_tick) & ~sleep;

    assign pif.to_watchdog = to_watchdog;
    assign pif.rate        = rate;
    assign pif.tick_in     = to_watchdog ? watchdog_base_tick : src_event;
    assign pif.clear       = to_watchdog ? clear_watchdog_instruction : write_count;

    shared_prescaler u_prescaler (
        .clock (clock),
        .reset (reset),
        .pif   (pif)
    );

    assign watchdog_prescaled_tick = to_watchdog & pif.tick_out;

    wire timer_event = to_watchdog ? src_event : pif.tick_out;

    // ****************************************
    // Timer count
    // ****************************************
    // Pin-driven events wait for the next Q2 or Q4 before reaching the count.
    logic pending_q;
    wire  increment = ~sleep & (source_pin ? (pending_q & sample_phase) : timer_event);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pending_q <= 1'b0;
        end else if (timer_event & source_pin) begin
            pending_q <= 1'b1;
        end else if (increment | ~source_pin) begin
            pending_q <= 1'b0;
        end
    end

    wire overflow = increment & ~write_count & (count_q == COUNT_TOP);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_q <= COUNT_RESET;
        end else if (write_count) begin
            count_q <= pwdata[7:0];
        end else if (increment) begin
            count_q <= count_q + 8'h01;
        end
    end

    // ****************************************
    // Interrupt control and event status
    // ****************************************
    wire ext_event = ext_rising ? pin_rise[1] : pin_fall[1];

    logic [7:0] intctl_d;
    logic [1:0] status_d;
    wire  [1:0] events = {ext_event, overflow};

    // Hardware setting a flag wins over software clearing it in the same cycle.
    always_comb begin
        intctl_d = write_intctl ? pwdata[7:0] : intctl_q;
        intctl_d[INT_OVF_FLAG] = intctl_d[INT_OVF_FLAG] | overflow;
        intctl_d[INT_EXT_FLAG] = intctl_d[INT_EXT_FLAG] | ext_event;
        status_d = (write_status ? (status_q & ~pwdata[1:0]) : status_q) | events;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            intctl_q <= INTCTL_RESET;
            status_q <= EVENT_RESET;
            mask_q   <= EVENT_RESET;
        end else begin
            intctl_q <= intctl_d;
            status_q <= status_d;
            if (write_mask) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    assign overflow_irq_request = intctl_q[INT_OVF_FLAG] & intctl_q[INT_OVF_ENABLE];
    assign ext_irq_request      = intctl_q[INT_EXT_FLAG] & intctl_q[INT_EXT_ENABLE];
    assign irq                  = |(status_q & mask_q);

endmodule : timer0_shared_prescaler
`default_nettype wire

// ===== timer0_shared_prescaler_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module timer0_shared_prescaler_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep,
    input wire logic watchdog_base_tick,
    input wire logic watchdog_prescaled_tick,
    input wire logic overflow_irq_request,
    input wire logic ext_irq_request,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence apb_access_s;
        psel && !penable ##1 psel && penable;
    endsequence

    a_pready_zero_wait: assert property (apb_access_s |-> pready) else $error("pready late");
    a_pready_only_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_slverr_only_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    a_ovf_request_sticky: assert property ($fell(overflow_irq_request) |-> $past(psel && penable && pwrite))
        else $error("overflow request dropped without a write");
    a_ext_request_sticky: assert property ($fell(ext_irq_request) |-> $past(psel && penable && pwrite))
        else $error("external request dropped without a write");
    a_irq_level_sticky: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("irq dropped without a write");
    a_sleep_no_overflow: assert property (sleep && !psel |=> !$rose(overflow_irq_request))
        else $error("overflow raised during sleep");
    a_wd_tick_cause: assert property (watchdog_prescaled_tick |-> watchdog_base_tick)
        else $error("watchdog tick without base tick");
endmodule : timer0_shared_prescaler_asserts
`default_nettype wire

// ===== count_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module count_source_model (
    input wire logic clock,
    output logic     count_input_pin
);
    initial count_input_pin = 1'b0;

    // Each level is held eight clocks so the three-flop synchroniser and the Q2/Q4 sampling see it.
    task automatic toggle(input int n);
        repeat (n) begin
            count_input_pin <= ~count_input_pin;
            repeat (8) @(posedge clock);
        end
    endtask : toggle
endmodule : count_source_model
`default_nettype wire

// ===== timer0_shared_prescaler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer0_shared_prescaler_tb;
    import timer0_pkg::*;
    logic        clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic        pready, pslverr, err, pin, ext_irq_pin = 1'b0, sleep = 1'b0;
    logic        clear_watchdog_instruction = 1'b0, watchdog_base_tick = 1'b0, wd_out;
    logic        ovf_req, ext_req, pullup_disable, irq;
    logic [5:0]  pin_direction;
    logic [7:0]  resets [6] = '{8'hFF, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00};
    int          num_errors = 0, comparisons = 0, i, d, wd_seen;

    always #50 clock = ~clock;

    timer0_shared_prescaler timer0_shared_prescaler_i (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_input_pin(pin), .ext_irq_pin(ext_irq_pin), .sleep(sleep),
        .clear_watchdog_instruction(clear_watchdog_instruction), .watchdog_base_tick(watchdog_base_tick),
        .watchdog_prescaled_tick(wd_out), .overflow_irq_request(ovf_req), .ext_irq_request(ext_req),
        .pullup_disable(pullup_disable), .pin_direction(pin_direction), .irq(irq));
    count_source_model count_source_model_i (.clock(clock), .count_input_pin(pin));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] dat);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, dat};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 16) begin
            num_errors++;
            $display("Error at %0t: no pready", $time);
            end_of_test();
        end
    endtask : apb

    task automatic pulse_clear;
        clear_watchdog_instruction <= 1'b1;
        @(posedge clock);
        clear_watchdog_instruction <= 1'b0;
        @(posedge clock);
    endtask : pulse_clear

    // Ownership moves first with the old rate kept, so a watchdog clear can precede the new rate.
    task automatic set_option(input logic [7:0] v);
        pulse_clear();
        apb(1'b1, OFFSET_COUNT, 8'h00);
        apb(1'b0, OFFSET_OPTION, 8'h00);
        apb(1'b1, OFFSET_OPTION, (q[7:0] & 8'hF7) | (v & 8'h08));
        pulse_clear();
        apb(1'b1, OFFSET_OPTION, v);
        pulse_clear();
        apb(1'b1, OFFSET_COUNT, 8'h00);
    endtask : set_option

    task automatic wd_ticks(input int n);
        repeat (n) begin
            watchdog_base_tick <= 1'b1;
            @(negedge clock);
            if (wd_out !== 1'b0) wd_seen++;
            @(posedge clock);
            watchdog_base_tick <= 1'b0;
            @(posedge clock);
        end
    endtask : wd_ticks

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (i = 0; i < 6; i++) begin
            apb(1'b0, OFFSET_OPTION + 8'(4 * i), 8'h00);
            check(q, 32'(resets[i]));
        end
        check(32'(pullup_disable), 32'h0000_0001);
        apb(1'b0, 8'h18, 8'h00);
        check({q[30:0], err}, 32'h0000_0001);
        apb(1'b1, OFFSET_DIRECTION, 8'hD5);
        check(32'(pin_direction), 32'h0000_0015);
        for (i = 0; i < 9; i++) begin
            d = (i < 8) ? (2 << i) : 1;
            set_option((i < 8) ? 8'(i) : 8'h08);
            repeat (14 * d) @(posedge clock);
            apb(1'b0, OFFSET_COUNT, 8'h00);
            check(32'(q inside {3, 4}), 32'h0000_0001);
        end
        apb(1'b1, OFFSET_COUNT, 8'hFE);
        repeat (16) @(posedge clock);
        apb(1'b0, OFFSET_INTCTL, 8'h00);
        check(q, 32'h0000_0004);
        check(32'(ovf_req), 32'h0000_0000);
        apb(1'b1, OFFSET_INTCTL, 8'h24);
        check(32'(ovf_req), 32'h0000_0001);
        apb(1'b1, OFFSET_MASK, 8'h01);
        check(32'(irq), 32'h0000_0001);
        apb(1'b1, OFFSET_MASK, 8'h00);
        check(32'(irq), 32'h0000_0000);
        apb(1'b0, OFFSET_STATUS, 8'h00);
        check(q, 32'h0000_0001);
        apb(1'b1, OFFSET_STATUS, 8'h01);
        apb(1'b0, OFFSET_STATUS, 8'h00);
        check(q, 32'h0000_0000);
        apb(1'b1, OFFSET_INTCTL, 8'h20);
        check(32'(ovf_req), 32'h0000_0000);
        sleep <= 1'b1;
        apb(1'b1, OFFSET_COUNT, 8'hFF);
        repeat (40) @(posedge clock);
        apb(1'b0, OFFSET_COUNT, 8'h00);
        check(q, 32'h0000_00FF);
        sleep <= 1'b0;
        repeat (12) @(posedge clock);
        apb(1'b0, OFFSET_INTCTL, 8'h00);
        check(q, 32'h0000_0024);
        for (i = 0; i < 3; i++) begin
            set_option((i == 2) ? 8'h20 : (i ? 8'h38 : 8'h28));
            count_source_model_i.toggle(3);
            apb(1'b0, OFFSET_COUNT, 8'h00);
            check(q, (i == 2) ? 32'h0000_0001 : 32'h0000_0002);
        end
        apb(1'b1, OFFSET_INTCTL, 8'h10);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, OFFSET_OPTION, i ? 8'h08 : 8'h48);
            ext_irq_pin <= ~ext_irq_pin;
            repeat (8) @(posedge clock);
            check(32'(ext_req), 32'(i < 2));
            apb(1'b1, OFFSET_INTCTL, 8'h10);
        end
        set_option(8'h07);
        repeat (900) @(posedge clock);
        apb(1'b1, OFFSET_COUNT, 8'h00);
        repeat (600) @(posedge clock);
        apb(1'b0, OFFSET_COUNT, 8'h00);
        check(q, 32'h0000_0000);
        set_option(8'h0A);
        wd_seen = 0;
        repeat (3) begin
            pulse_clear();
            wd_ticks(3);
        end
        check(32'(wd_seen), 32'h0000_0000);
        wd_ticks(1);
        check(32'(wd_seen), 32'h0000_0001);
        set_option(8'h02);
        wd_ticks(4);
        check(32'(wd_seen), 32'h0000_0001);
        end_of_test();
    end
endmodule : timer0_shared_prescaler_tb

bind timer0_shared_prescaler timer0_shared_prescaler_asserts timer0_shared_prescaler_asserts_i (.clock(clock),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .sleep(sleep), .watchdog_base_tick(watchdog_base_tick), .watchdog_prescaled_tick(watchdog_prescaled_tick),
    .overflow_irq_request(overflow_irq_request), .ext_irq_request(ext_irq_request), .irq(irq));
`default_nettype wire
